// File: logic/cldm_pkg.sv
// Constants and types shared by the command list data mover.
// Assumes byte-addressed system memory reached in whole 32-bit words.
package cldm_pkg;

	// Bus and list sizes
	localparam int DW         = 32;
	localparam int AW         = 32;
	localparam int MAX_SLOTS  = 32;
	localparam int FIFO_DEPTH = 8;
	localparam int CNT_W      = 16;
	localparam int WORD_SHIFT = 2;

	// Slot header in the command list: stride, words fetched, word roles
	localparam int HDR_BYTES = 32;
	localparam int HDR_WORDS = 4;
	localparam int HW_FLAGS  = 0;
	localparam int HW_CFRAME = 1;
	localparam int HW_PRD    = 2;
	localparam int HW_COUNT  = 3;
	localparam int HF_QUEUED = 0;

	// Command frame length in words
	localparam int FIS_WORDS = 5;

	// Drive status byte
	localparam int STAT_W = 8;
	localparam int SB_ERR = 0;
	localparam int SB_DRQ = 3;
	localparam int SB_BSY = 7;

	// Fields of received control frames
	localparam int TAG_W   = 5;
	localparam int DIR_BIT = 16;

	// Received frame types
	localparam int         FTYPE_W = 3;
	localparam logic [2:0] FT_REG  = 3'h0;
	localparam logic [2:0] FT_PIO  = 3'h1;
	localparam logic [2:0] FT_DMA  = 3'h2;
	localparam logic [2:0] FT_DATA = 3'h3;
	localparam logic [2:0] FT_ACT  = 3'h4;
	localparam logic [2:0] FT_SDB  = 3'h5;

	typedef enum logic [2:0] {
		CL_IDLE,
		CL_HDR,
		CL_CFIS,
		CL_WAIT,
		CL_RX,
		CL_TX,
		CL_HALT
	} cldm_state_t;

endpackage

// File: logic/cldm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on clk; ready and valid come from flip-flops.
`timescale 1ns/1ns
module cldm_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// Fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// Drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [PW:0]   cnt_q;
	logic [PW:0]   cnt_d;
	logic          push;
	logic          pop;

	assign push     = in_valid && in_ready;
	assign pop      = out_valid && out_ready;
	assign cnt_d    = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
	assign out_data = mem[rd_q];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	// Flags are registered from the next count so they stay honest in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_q      <= '0;
			rd_q      <= '0;
			cnt_q     <= '0;
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + PW'(1);
			if (pop)
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + PW'(1);
			cnt_q     <= cnt_d;
			in_ready  <= cnt_d != (PW+1)'(DEPTH);
			out_valid <= cnt_d != '0;
		end
	end

endmodule

// File: logic/cldm_pick.sv
// Fixed-priority picker: lowest requesting index wins.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module cldm_pick #(
	parameter int  N  = 32,
	localparam int IW = (N > 1) ? $clog2(N) : 1
) (
	// Requests
	input  wire logic [N-1:0] req,
	// Grant
	output logic              gnt_valid,
	output logic [IW-1:0]     gnt_idx
);
	always_comb
	begin
		gnt_valid = 1'b0;
		gnt_idx   = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (req[i])
			begin
				gnt_valid = 1'b1;
				gnt_idx   = IW'(i);
			end
		end
	end

endmodule

// File: logic/cldm_mover.sv
// Command list data mover: fetches slot headers and command frames, walks the list, moves data.
// Assumes a one-word req/ack memory master bus and a framed link to the drive on the same clock.
`timescale 1ns/1ns
module cldm_mover #(
	parameter int   SLOTS         = cldm_pkg::MAX_SLOTS,
	parameter logic PIO_ONE_BLOCK = 1'b1,
	localparam int  SW            = (SLOTS > 1) ? $clog2(SLOTS) : 1
) (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rstn,
	// Native command issue
	input  wire logic                         run,
	input  wire logic [cldm_pkg::AW-1:0]      cl_base,
	input  wire logic                         issue_valid,
	input  wire logic [SW-1:0]                issue_slot,
	// Slot and drive state
	output logic [SLOTS-1:0]                  ci_q,
	output logic [SLOTS-1:0]                  sact_q,
	output logic [cldm_pkg::STAT_W-1:0]       dev_status_q,
	output logic                              err_q,
	output logic                              busy_q,
	// Memory master
	output logic                              mem_req_q,
	output logic                              mem_we_q,
	output logic [cldm_pkg::AW-1:0]           mem_addr_q,
	output logic [cldm_pkg::DW-1:0]           mem_wdata_q,
	input  wire logic                         mem_ack,
	input  wire logic [cldm_pkg::DW-1:0]      mem_rdata,
	// Link toward the drive
	output logic                              tx_valid_q,
	output logic [cldm_pkg::DW-1:0]           tx_data_q,
	output logic                              tx_last_q,
	input  wire logic                         tx_ready,
	// Link from the drive
	input  wire logic                         rx_valid,
	input  wire logic [cldm_pkg::FTYPE_W-1:0] rx_type,
	input  wire logic [cldm_pkg::DW-1:0]      rx_data,
	input  wire logic                         rx_last,
	output logic                              rx_ready
);
	import cldm_pkg::*;

	localparam int FW  = FTYPE_W + 1 + DW;
	localparam int HIW = $clog2(HDR_WORDS);

	cldm_state_t       state_q;
	cldm_state_t       state_d;
	logic [CNT_W-1:0]  idx_q;
	logic [CNT_W-1:0]  idx_d;
	logic [SW-1:0]     cur_q;
	logic [SW-1:0]     cur_d;
	logic              qdata_q;
	logic              qdata_d;
	logic              pio_q;
	logic              pio_d;
	logic              dir_q;
	logic              dir_d;
	logic [STAT_W-1:0] pio_st_q;
	logic [DW-1:0]     hdr_q [HDR_WORDS];
	logic [FW-1:0]     head_w;
	logic [FTYPE_W-1:0] head_t;
	logic [DW-1:0]     head_d;
	logic              head_v;
	logic              head_l;
	logic              head_clean;
	logic              pio_clean;
	logic              pop;
	logic              pick_v;
	logic [SW-1:0]     pick_idx;
	logic              mem_done;
	logic              tx_done;
	logic [AW-1:0]     word_off;
	logic [AW-1:0]     slot_base;
	logic [AW-1:0]     cur_addr;
	logic [CNT_W-1:0]  tx_end_idx;
	logic              start_rd;
	logic              start_wr;
	logic              issue_ok;
	logic [SLOTS-1:0]  cur_mask;
	logic [SLOTS-1:0]  set_mask;
	logic [SLOTS-1:0]  ci_d;
	logic [SLOTS-1:0]  sact_d;
	logic [SLOTS-1:0]  sdb_clr;
	logic              pio_ld;
	logic              stat_ld;
	logic [STAT_W-1:0] stat_v;
	logic              done_ok;
	logic              q_sent;
	logic              halt;
	logic              xfer_end;

	// Every drive frame, control or data, queues here so a slow memory stalls the link
	cldm_fifo #(
		.W     (FW),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (rx_valid),
		.in_data   ({rx_type, rx_last, rx_data}),
		.in_ready  (rx_ready),
		.out_valid (head_v),
		.out_data  (head_w),
		.out_ready (pop)
	);

	cldm_pick #(
		.N (SLOTS)
	) u_pick (
		.req       (ci_q & ~sact_q),
		.gnt_valid (pick_v),
		.gnt_idx   (pick_idx)
	);

	assign head_t     = head_w[FW-1 -: FTYPE_W];
	assign head_l     = head_w[DW];
	assign head_d     = head_w[DW-1:0];
	assign head_clean = !head_d[SB_BSY] && !head_d[SB_DRQ] && !head_d[SB_ERR];
	assign pio_clean  = !pio_st_q[SB_BSY] && !pio_st_q[SB_DRQ] && !pio_st_q[SB_ERR];
	assign mem_done   = mem_req_q && mem_ack;
	assign tx_done    = tx_valid_q && tx_ready;
	assign word_off   = AW'(idx_q) << WORD_SHIFT;
	assign slot_base  = cl_base + AW'(cur_q) * AW'(HDR_BYTES);
	assign cur_addr   = (state_q == CL_HDR) ? slot_base + word_off :
	                    (state_q == CL_CFIS) ? hdr_q[HW_CFRAME][AW-1:0] + word_off :
	                    hdr_q[HW_PRD][AW-1:0] + word_off;
	assign tx_end_idx = (state_q == CL_CFIS) ? CNT_W'(FIS_WORDS - 1) :
	                    hdr_q[HW_COUNT][CNT_W-1:0] - CNT_W'(1);
	assign start_rd   = run && !mem_req_q && !tx_valid_q &&
	                    (state_q == CL_HDR || state_q == CL_CFIS || state_q == CL_TX);
	assign start_wr   = run && !mem_req_q && state_q == CL_RX && head_v && head_t == FT_DATA;

	// Only the native issue strobe sets a slot; a set in the clearing cycle wins
	assign issue_ok = run && issue_valid && (32'(issue_slot) < SLOTS);
	assign cur_mask = SLOTS'(1) << cur_q;
	assign set_mask = issue_ok ? SLOTS'(1) << issue_slot : '0;
	assign ci_d     = run ? (ci_q & ~((done_ok || q_sent) ? cur_mask : '0)) | set_mask : '0;
	assign sact_d   = run ? (sact_q & ~sdb_clr) | (q_sent ? cur_mask : '0) : '0;

	always_comb
	begin
		state_d  = state_q;
		idx_d    = idx_q;
		cur_d    = cur_q;
		qdata_d  = qdata_q;
		pio_d    = pio_q;
		dir_d    = dir_q;
		pop      = 1'b0;
		pio_ld   = 1'b0;
		stat_ld  = 1'b0;
		stat_v   = head_d[STAT_W-1:0];
		done_ok  = 1'b0;
		q_sent   = 1'b0;
		halt     = 1'b0;
		xfer_end = 1'b0;
		sdb_clr  = '0;
		case (state_q)
		CL_IDLE:
		begin
			if (head_v)
			begin
				pop = 1'b1;
				if (head_t == FT_DMA)
				begin
					cur_d   = (SLOTS == 1) ? '0 : SW'(head_d[TAG_W-1:0]);
					qdata_d = 1'b1;
					dir_d   = head_d[DIR_BIT];
					idx_d   = '0;
					state_d = CL_HDR;
				end
				else if (head_t == FT_SDB)
					sdb_clr = head_d[SLOTS-1:0];
			end
			else if (pick_v)
			begin
				cur_d   = pick_idx;
				qdata_d = 1'b0;
				pio_d   = 1'b0;
				idx_d   = '0;
				state_d = CL_HDR;
			end
		end
		CL_HDR:
		begin
			if (mem_done)
			begin
				idx_d = idx_q + CNT_W'(1);
				if (idx_q == CNT_W'(HDR_WORDS - 1))
				begin
					idx_d   = '0;
					state_d = !qdata_q ? CL_CFIS : (dir_q ? CL_RX : CL_TX);
				end
			end
		end
		CL_CFIS:
		begin
			if (tx_done)
			begin
				idx_d = idx_q + CNT_W'(1);
				if (tx_last_q)
				begin
					idx_d   = '0;
					q_sent  = hdr_q[HW_FLAGS][HF_QUEUED];
					state_d = hdr_q[HW_FLAGS][HF_QUEUED] ? CL_IDLE : CL_WAIT;
				end
			end
		end
		CL_WAIT:
		begin
			if (head_v)
			begin
				pop   = head_t != FT_DATA;
				idx_d = '0;
				dir_d = head_d[DIR_BIT];
				case (head_t)
				FT_REG:
				begin
					stat_ld = 1'b1;
					halt    = head_d[SB_ERR];
					done_ok = head_clean;
					state_d = head_clean ? CL_IDLE : CL_WAIT;
				end
				FT_PIO:
				begin
					pio_d   = 1'b1;
					pio_ld  = 1'b1;
					state_d = head_d[DIR_BIT] ? CL_RX : CL_TX;
				end
				FT_DMA:
					state_d = head_d[DIR_BIT] ? CL_RX : CL_TX;
				FT_ACT:
					state_d = CL_TX;
				FT_DATA:
					state_d = CL_RX;
				default:
					state_d = CL_WAIT;
				endcase
			end
		end
		CL_RX:
		begin
			if (mem_done)
			begin
				pop      = 1'b1;
				idx_d    = idx_q + CNT_W'(1);
				xfer_end = head_l;
			end
		end
		CL_TX:
		begin
			if (tx_done)
			begin
				idx_d    = idx_q + CNT_W'(1);
				xfer_end = tx_last_q;
			end
		end
		default:
			state_d = state_q;
		endcase
		// End of a data phase: queued waits for completion bits, PIO uses its early status
		if (xfer_end)
		begin
			idx_d = '0;
			if (qdata_q)
				state_d = CL_IDLE;
			else if (!pio_q)
				state_d = CL_WAIT;
			else
			begin
				stat_ld = 1'b1;
				stat_v  = pio_st_q;
				halt    = pio_st_q[SB_ERR] || (PIO_ONE_BLOCK && pio_st_q[SB_DRQ]);
				done_ok = pio_clean;
				state_d = pio_clean ? CL_IDLE : CL_WAIT;
			end
		end
		if (halt)
			state_d = CL_HALT;
		if (!run)
			state_d = CL_IDLE;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= CL_IDLE;
			idx_q   <= '0;
			cur_q   <= '0;
			qdata_q <= 1'b0;
			pio_q   <= 1'b0;
			dir_q   <= 1'b0;
			busy_q  <= 1'b0;
			ci_q    <= '0;
			sact_q  <= '0;
		end
		else
		begin
			state_q <= state_d;
			idx_q   <= idx_d;
			cur_q   <= cur_d;
			qdata_q <= qdata_d;
			pio_q   <= pio_d;
			dir_q   <= dir_d;
			busy_q  <= state_d != CL_IDLE;
			ci_q    <= ci_d;
			sact_q  <= sact_d;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dev_status_q <= '0;
			pio_st_q     <= '0;
			err_q        <= 1'b0;
		end
		else
		begin
			if (stat_ld)
				dev_status_q <= stat_v;
			if (pio_ld)
				pio_st_q <= head_d[STAT_W-1:0];
			err_q <= run && (err_q || halt);
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < HDR_WORDS; i++)
				hdr_q[i] <= '0;
		end
		else if (state_q == CL_HDR && mem_done)
			hdr_q[idx_q[HIW-1:0]] <= mem_rdata;
	end

	// Dropping run abandons a bus cycle; the system must quiesce the bus first
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_addr_q  <= '0;
			mem_wdata_q <= '0;
		end
		else if (!run || mem_done)
			mem_req_q <= 1'b0;
		else if (start_rd || start_wr)
		begin
			mem_req_q   <= 1'b1;
			mem_we_q    <= start_wr;
			mem_addr_q  <= cur_addr;
			mem_wdata_q <= head_d;
		end
	end

	// Frame words pass to the link untouched
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tx_valid_q <= 1'b0;
			tx_data_q  <= '0;
			tx_last_q  <= 1'b0;
		end
		else if (!run || tx_done)
			tx_valid_q <= 1'b0;
		else if (mem_done && (state_q == CL_CFIS || state_q == CL_TX))
		begin
			tx_valid_q <= 1'b1;
			tx_data_q  <= mem_rdata;
			tx_last_q  <= idx_q == tx_end_idx;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_slots_range: assert property (SLOTS >= 1 && SLOTS <= MAX_SLOTS)
		else $error("slot count out of range");
	a_single_entry: assert property (SLOTS > 1 || cur_q == '0)
		else $error("single-entry list used a nonzero slot");
	a_frame_fetched: assert property ($rose(tx_valid_q) |-> $past(mem_done) && !$past(mem_we_q))
		else $error("link word not fetched from memory");
	a_frame_verbatim: assert property ($rose(tx_valid_q) |-> tx_data_q == $past(mem_rdata))
		else $error("link word altered");
	a_data_mastered: assert property ($rose(mem_req_q) && mem_we_q |-> mem_wdata_q == $past(head_d))
		else $error("memory write not from drive data");
	a_fetch_issued: assert property (state_q == CL_IDLE && run && !head_v && pick_v ##1 run
		|-> state_q == CL_HDR ##1 mem_req_q && mem_addr_q == $past(slot_base))
		else $error("pending slot not fetched");
	a_tag_slot: assert property (SLOTS > 1 && run && state_q == CL_IDLE && head_v && head_t == FT_DMA
		|=> qdata_q && cur_q == SW'($past(head_d[TAG_W-1:0])))
		else $error("setup tag not used as slot");
	a_lowest_first: assert property (state_q == CL_IDLE && pick_v
		|-> ((ci_q & ~sact_q) & ((SLOTS'(1) << pick_idx) - SLOTS'(1))) == '0)
		else $error("lower pending slot skipped");
	a_advance_clean: assert property (done_ok && run
		|-> !stat_v[SB_BSY] && !stat_v[SB_DRQ] && !stat_v[SB_ERR] ##1 state_q == CL_IDLE)
		else $error("list advanced with drive busy");
	a_walk_clears: assert property (done_ok && run && !issue_valid |=> !ci_q[$past(cur_q)])
		else $error("finished slot still pending");
	a_pio_status: assert property (xfer_end && pio_q && !qdata_q && run |=> dev_status_q == $past(pio_st_q))
		else $error("PIO ending status not applied");
	a_pio_block: assert property (PIO_ONE_BLOCK && xfer_end && pio_q && !qdata_q && pio_st_q[SB_DRQ] && run
		|=> err_q && state_q == CL_HALT)
		else $error("second PIO block accepted");
	a_slot_native: assert property (|(ci_q & ~$past(ci_q)) |-> $past(issue_valid))
		else $error("slot set without native issue");

	c_queued_sent: cover property (q_sent);
	c_pio_done: cover property (xfer_end && pio_q ##1 state_q == CL_IDLE);
	c_two_walked: cover property (done_ok ##[1:60] done_ok);
	c_halted: cover property (state_q == CL_HALT);

endmodule

// File: dv/cldm_drive_model.sv
// Behavioural drive on the link side of the command list data mover.
// Assumes word 0 of each command frame holds a bench code: [2:0] reply kind, [12:8] tag.
`timescale 1ns/1ns
module cldm_drive_model (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rstn,
	// Frames from the mover
	input  wire logic                    tx_valid,
	input  wire logic [cldm_pkg::DW-1:0] tx_data,
	input  wire logic                    tx_last,
	output logic                         tx_ready,
	// Frames to the mover
	output logic                         rx_valid,
	output logic [2:0]                   rx_type,
	output logic [cldm_pkg::DW-1:0]      rx_data,
	output logic                         rx_last,
	input  wire logic                    rx_ready
);
	import cldm_pkg::*;
	logic [DW-1:0] fw [5];
	logic [2:0]    n;
	logic [3:0]    st;
	logic [35:0]   rq [$];
	logic [35:0]   w;

	task automatic put(input logic [2:0] t, input logic l, input logic [31:0] d);
		rq.push_back({t, l, d});
	endtask

	task automatic data_frame();
		for (int i = 0; i < fw[2][4:0]; i++)
			put(FT_DATA, i == fw[2][4:0] - 1, fw[1] + i);
	endtask

	always @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			n <= 3'h0;
			st <= 4'h0;
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_type <= 3'h0;
			rx_data <= 32'h0;
			rx_last <= 1'b0;
			rq.delete();
		end
		else
		begin
			// Stall one cycle in four so both prompt and slow answers occur
			st <= st + 4'h1;
			tx_ready <= st[1:0] != 2'h0;
			if (tx_valid && tx_ready)
			begin
				fw[n] = tx_data;
				n <= tx_last ? 3'h0 : n + 3'h1;
				if (tx_last)
				begin
					case (fw[0][2:0])
						3'h0: begin data_frame(); put(FT_REG, 1'b1, 32'h50); end
						3'h1: begin data_frame(); put(FT_REG, 1'b1, 32'h80); put(FT_REG, 1'b1, 32'h50); end
						3'h2: put(FT_REG, 1'b1, 32'h51);
						3'h3:
						begin
							put(FT_DMA, 1'b1, {15'h0, 1'b1, 11'h0, fw[0][12:8]});
							data_frame();
							put(FT_SDB, 1'b1, 32'h1 << fw[0][12:8]);
						end
						default: begin put(FT_PIO, 1'b1, 32'h00010054); data_frame(); end
					endcase
				end
			end
			if (!rx_valid || rx_ready)
			begin
				if (rq.size() > 0 && st[2])
				begin
					w = rq.pop_front();
					rx_valid <= 1'b1;
					{rx_type, rx_last, rx_data} <= w;
				end
				else
				begin
					// Released lines never keep the last word
					rx_valid <= 1'b0;
					rx_data <= ~rx_data;
					rx_type <= ~rx_type;
				end
			end
		end
	end
endmodule

// File: dv/tb.sv
// Self-checking bench for the command list data mover with memory and drive models.
// Assumes the drive model replies by the kind code that the bench puts in each frame.
`timescale 1ns/1ns
module tb;
	import cldm_pkg::*;
	logic          clk = 1'b0;
	logic          rstn, run, issue_valid, mem_ack, tx_ready, rx_valid, rx_last, rx_ready;
	logic [4:0]    issue_slot;
	logic [31:0]   ci_q, sact_q;
	logic [7:0]    dev_status_q;
	logic          err_q, busy_q, mem_req_q, mem_we_q, tx_valid_q, tx_last_q;
	logic [31:0]   mem_addr_q, mem_wdata_q, mem_rdata, tx_data_q, rx_data, ci_p;
	logic [2:0]    rx_type;
	logic [1:0]    lat;
	logic [15:0]   seed = 16'h0029;
	logic [31:0]   mem [2048];
	logic [31:0]   exp_seed [32];
	logic [4:0]    exp_cnt [32];
	logic [4:0]    order [$];
	int            tw, bad_count, compares;

	always #25 clk = ~clk;
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected buffer word: the frame's seed word plus the word's position
	function automatic logic [31:0] exp_word(input int s, input int i);
		return exp_seed[s] + 32'(i);
	endfunction

	always @(posedge clk) seed <= lfsr_next(seed);

	cldm_mover dut (.clk(clk), .rstn(rstn), .run(run), .cl_base(32'h100), .issue_valid(issue_valid),
		.issue_slot(issue_slot), .ci_q(ci_q), .sact_q(sact_q), .dev_status_q(dev_status_q), .err_q(err_q),
		.busy_q(busy_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
		.mem_wdata_q(mem_wdata_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tx_valid_q(tx_valid_q),
		.tx_data_q(tx_data_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_type(rx_type), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready));
	cldm_drive_model drive (.clk(clk), .rstn(rstn), .tx_valid(tx_valid_q), .tx_data(tx_data_q),
		.tx_last(tx_last_q), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_type(rx_type),
		.rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready));

	task automatic cmp(input logic [31:0] a, input logic [31:0] b);
		compares++;
		if (a !== b)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, a, b);
		end
	endtask

	task automatic final_report();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Memory answers after 0 to 3 cycles; released read data is inverted
	always @(posedge clk)
	begin
		if (mem_req_q && !mem_ack && lat == 2'h0)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr_q[12:2]];
			if (mem_we_q)
				mem[mem_addr_q[12:2]] <= mem_wdata_q;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			lat <= (mem_req_q && !mem_ack) ? lat - 2'h1 : seed[1:0];
		end
	end

	// Watch frames sent to the drive and slots that complete
	always @(posedge clk)
	begin
		if (tx_valid_q && tx_ready)
		begin
			if (tw == 0)
				order.push_back(tx_data_q[12:8]);
			tw = tx_last_q ? 0 : tw + 1;
		end
		if (run && rstn && ((ci_p & ~ci_q & ~sact_q) != 32'h0))
			cmp(dev_status_q & 8'h89, 8'h00);
		ci_p <= ci_q;
	end

	task automatic prep(input int s, input logic [2:0] k, input logic [4:0] c);
		int h;
		int f;
		h = (32'h100 + s * HDR_BYTES) / 4;
		f = (32'h600 + s * 32) / 4;
		mem[h + HW_FLAGS] = {31'h0, k == 3'h3};
		mem[h + HW_CFRAME] = 32'h600 + s * 32;
		mem[h + HW_PRD] = 32'ha00 + s * 64;
		mem[h + HW_COUNT] = {27'h0, c};
		mem[f] = {19'h0, s[4:0], 5'h0, k};
		mem[f + 1] = {seed, 16'h0};
		mem[f + 2] = {27'h0, c};
		for (int i = 0; i < 16; i++)
			mem[(32'ha00 + s * 64) / 4 + i] = 32'h0;
		exp_seed[s] = {seed, 16'h0};
		exp_cnt[s] = c;
	endtask

	// Software notifies a slot that prep has filled: issue strobe for one cycle
	task automatic issue(input int s);
		issue_valid <= 1'b1;
		issue_slot <= s[4:0];
		@(posedge clk);
		issue_valid <= 1'b0;
	endtask

	task automatic wait_done();
		int t;
		t = 0;
		repeat (2) @(posedge clk);
		while ((busy_q !== 1'b0 || ci_q !== 32'h0 || sact_q !== 32'h0) && t < 3000)
		begin
			@(posedge clk);
			t++;
		end
		cmp(t < 3000, 1'b1);
	endtask

	task automatic chk_buf(input int s);
		for (int i = 0; i < exp_cnt[s]; i++)
			cmp(mem[(32'ha00 + s * 64) / 4 + i], exp_word(s, i));
	endtask

	initial
	begin
		int t;
		int s;
		logic [4:0] exp_o [3];
		exp_o = '{5'd5, 5'd1, 5'd3};
		rstn = 1'b0;
		run = 1'b0;
		issue_valid = 1'b0;
		issue_slot = 5'h0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		cmp(rx_ready, 1'b1);
		// Non-queued walk, never mixed with queued work: FIFO full, one word, PIO
		prep(5, 3'h0, 5'd12);
		prep(1, 3'h1, 5'd1);
		prep(3, 3'h4, {1'b0, seed[3:0]} + 5'd1);
		run <= 1'b1;
		@(posedge clk);
		issue(5);
		repeat (3) @(posedge clk);
		issue(3);
		@(posedge clk);
		issue(1);
		wait_done();
		cmp(order.size(), 3);
		for (int i = 0; i < 3; i++)
			cmp(order[i], exp_o[i]);
		chk_buf(5);
		chk_buf(1);
		chk_buf(3);
		cmp(dev_status_q, 8'h54);
		cmp(err_q, 1'b0);
		// Queued pair
		prep(7, 3'h3, {1'b0, seed[3:0]} + 5'd1);
		prep(2, 3'h3, 5'd9);
		issue(7);
		@(posedge clk);
		issue(2);
		wait_done();
		chk_buf(7);
		chk_buf(2);
		// Drive error halts the walk until run drops
		prep(4, 3'h2, 5'd1);
		issue(4);
		t = 0;
		while (err_q !== 1'b1 && t < 2000)
		begin
			@(posedge clk);
			t++;
		end
		cmp(err_q, 1'b1);
		repeat (20) @(posedge clk);
		cmp(ci_q[4], 1'b1);
		run <= 1'b0;
		repeat (2) @(posedge clk);
		cmp(ci_q, 32'h0);
		cmp(err_q, 1'b0);
		issue(6);
		repeat (2) @(posedge clk);
		cmp(ci_q, 32'h0);
		run <= 1'b1;
		// Random slots and kinds
		for (int r = 0; r < 4; r++)
		begin
			s = seed[4:0];
			prep(s, seed[7] ? 3'h4 : 3'h0, {1'b0, seed[11:8]} + 5'd1);
			issue(s);
			wait_done();
			chk_buf(s);
		end
		final_report();
	end

	initial
	begin
		#(40000 * 50);
		bad_count++;
		final_report();
	end
endmodule
